// file: verilog/tpu_io_pkg.sv
// Package with register map, field layouts and reset values of the timer pin I/O block.
package tpu_io_pkg;
  localparam logic [3:0] ADDR_IO_CH5 = 4'h0;
  localparam logic [3:0] ADDR_IO_HIGH_CH0 = 4'h4;
  localparam logic [3:0] ADDR_IO_LOW_CH0 = 4'h8;
  localparam logic [3:0] ADDR_MODE_CH0 = 4'hc;
  localparam logic [3:0] ADDR_PIN_STATUS = 4'h0;
  localparam int FIELD_B_LSB = 4;
  localparam int FIELD_A_LSB = 0;
  localparam int FIELD_C_LSB = 0;
  localparam int BUF_A_BIT = 4;
  localparam logic [7:0] IO_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_CLOCK = 2'b01
  } cap_src_t;
endpackage

// file: verilog/pin_sync.sv
// Three-stage synchroniser for an input pin, with a qualified stable level.
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pin and synchronised level.
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule

// file: verilog/io_channel.sv
// One general register's I/O mode decode: compare pin drive or capture strobe.
`timescale 1ns/100ps
module io_channel #(
  parameter bit HAS_CLOCK_SRC = 1'b0
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Mode and qualifiers.
  input wire logic [3:0] mode,
  input wire logic inhibit,
  // Events.
  input wire logic compare_match,
  input wire logic pin_level,
  input wire logic count_tick,
  // Pin drive and capture strobe.
  output logic pin_out,
  output logic pin_oe,
  output logic capture
);
  logic prev_q;
  logic out_q;
  logic [3:0] mode_q;
  logic rise;
  logic fall;
  logic is_compare;
  logic cap_edge;

  assign is_compare = !mode[3] && (mode[1:0] != 2'b00);
  assign rise = pin_level && !prev_q;
  assign fall = !pin_level && prev_q;

  always_comb begin
    cap_edge = 1'b0;
    if (HAS_CLOCK_SRC && mode[2]) begin
      cap_edge = count_tick;
    end else if (mode[1]) begin
      cap_edge = rise || fall;
    end else if (mode[0]) begin
      cap_edge = fall;
    end else begin
      cap_edge = rise;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_level;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture <= 1'b0;
    end else begin
      capture <= mode[3] && !inhibit && cap_edge;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= 4'h0;
      out_q <= 1'b0;
    end else begin
      mode_q <= mode;
      if (mode != mode_q) begin
        out_q <= mode[2];
      end else if (compare_match && is_compare && !inhibit) begin
        case (mode[1:0])
          2'b01: out_q <= 1'b0;
          2'b10: out_q <= 1'b1;
          default: out_q <= !out_q;
        endcase
      end
    end
  end

  assign pin_out = out_q;
  assign pin_oe = is_compare && !inhibit;
endmodule

// file: verilog/timer_pin_io_mode_control.sv
// Top of the timer pin I/O mode control with its AXI4-Lite register slave.
`timescale 1ns/100ps
module timer_pin_io_mode_control (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Compare matches from the counters.
  input wire logic ch5_match_b,
  input wire logic ch0_match_a,
  input wire logic ch0_match_c,
  // Channel one count tick, same clock domain.
  input wire logic ch1_counter_tick,
  // Timer pins.
  input wire logic ch5_pin_b_i,
  output logic ch5_pin_b_o,
  output logic ch5_pin_b_oe,
  input wire logic ch0_pin_a_i,
  output logic ch0_pin_a_o,
  output logic ch0_pin_a_oe,
  input wire logic ch0_pin_c_i,
  output logic ch0_pin_c_o,
  output logic ch0_pin_c_oe,
  // Capture strobes to the general registers.
  output logic ch5_general_reg_b_capture,
  output logic ch0_general_reg_a_capture,
  output logic ch0_general_reg_c_capture
);
  logic [7:0] timer_io_control_ch5_q;
  logic [7:0] timer_io_control_high_ch0_q;
  logic [7:0] timer_io_control_low_ch0_q;
  logic [7:0] ch0_timer_mode_reg_q;
  logic [3:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic wr_go;
  logic [3:0] mode_b5;
  logic reg_a_buffer_enable;
  logic lvl_b5;
  logic lvl_a0;
  logic lvl_c0;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tpu_io_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q == tpu_io_pkg::ADDR_IO_CH5 || awaddr_q == tpu_io_pkg::ADDR_IO_HIGH_CH0 ||
          awaddr_q == tpu_io_pkg::ADDR_IO_LOW_CH0 || awaddr_q == tpu_io_pkg::ADDR_MODE_CH0) begin
        s_axi_bresp <= tpu_io_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= tpu_io_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_io_control_ch5_q <= tpu_io_pkg::IO_RESET;
      timer_io_control_high_ch0_q <= tpu_io_pkg::IO_RESET;
      timer_io_control_low_ch0_q <= tpu_io_pkg::IO_RESET;
      ch0_timer_mode_reg_q <= tpu_io_pkg::MODE_RESET;
    end else if (wr_go && wstrb_q[0]) begin
      if (awaddr_q == tpu_io_pkg::ADDR_IO_CH5) begin
        timer_io_control_ch5_q <= wdata_q[7:0];
      end else if (awaddr_q == tpu_io_pkg::ADDR_IO_HIGH_CH0) begin
        timer_io_control_high_ch0_q <= wdata_q[7:0];
      end else if (awaddr_q == tpu_io_pkg::ADDR_IO_LOW_CH0) begin
        timer_io_control_low_ch0_q <= wdata_q[7:0];
      end else if (awaddr_q == tpu_io_pkg::ADDR_MODE_CH0) begin
        ch0_timer_mode_reg_q <= wdata_q[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tpu_io_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tpu_io_pkg::RESP_OKAY;
      if (s_axi_araddr == tpu_io_pkg::ADDR_IO_CH5) begin
        s_axi_rdata <= {24'h00_0000, timer_io_control_ch5_q};
      end else if (s_axi_araddr == tpu_io_pkg::ADDR_IO_HIGH_CH0) begin
        s_axi_rdata <= {24'h00_0000, timer_io_control_high_ch0_q};
      end else if (s_axi_araddr == tpu_io_pkg::ADDR_IO_LOW_CH0) begin
        s_axi_rdata <= {24'h00_0000, timer_io_control_low_ch0_q};
      end else if (s_axi_araddr == tpu_io_pkg::ADDR_MODE_CH0) begin
        s_axi_rdata <= {24'h00_0000, ch0_timer_mode_reg_q};
      end else if (s_axi_araddr == 4'h0 + 4'h0 + 4'h0 + tpu_io_pkg::ADDR_PIN_STATUS + 4'h0) begin
        s_axi_rdata <= 32'h0000_0000;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= tpu_io_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  pin_sync u_sync_b5 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ch5_pin_b_i),
    .level(lvl_b5)
  );

  pin_sync u_sync_a0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ch0_pin_a_i),
    .level(lvl_a0)
  );

  pin_sync u_sync_c0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ch0_pin_c_i),
    .level(lvl_c0)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode per general register.
  assign mode_b5 = timer_io_control_ch5_q[tpu_io_pkg::FIELD_B_LSB +: 4];
  assign reg_a_buffer_enable = ch0_timer_mode_reg_q[tpu_io_pkg::BUF_A_BIT];

  io_channel #(
    .HAS_CLOCK_SRC(1'b0)
  ) u_ch5_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode_b5),
    .inhibit(1'b0),
    .compare_match(ch5_match_b),
    .pin_level(lvl_b5),
    .count_tick(1'b0),
    .pin_out(ch5_pin_b_o),
    .pin_oe(ch5_pin_b_oe),
    .capture(ch5_general_reg_b_capture)
  );

  io_channel #(
    .HAS_CLOCK_SRC(1'b1)
  ) u_ch0_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(timer_io_control_high_ch0_q[tpu_io_pkg::FIELD_A_LSB +: 4]),
    .inhibit(1'b0),
    .compare_match(ch0_match_a),
    .pin_level(lvl_a0),
    .count_tick(ch1_counter_tick),
    .pin_out(ch0_pin_a_o),
    .pin_oe(ch0_pin_a_oe),
    .capture(ch0_general_reg_a_capture)
  );

  io_channel #(
    .HAS_CLOCK_SRC(1'b1)
  ) u_ch0_c (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(timer_io_control_low_ch0_q[tpu_io_pkg::FIELD_C_LSB +: 4]),
    .inhibit(reg_a_buffer_enable),
    .compare_match(ch0_match_c),
    .pin_level(lvl_c0),
    .count_tick(ch1_counter_tick),
    .pin_out(ch0_pin_c_o),
    .pin_oe(ch0_pin_c_oe),
    .capture(ch0_general_reg_c_capture)
  );
endmodule

// file: testbench/pin_partner.sv
// Model of the external timer pins facing the channel.
`timescale 1ns/100ps
module pin_partner (
  // Levels applied from outside.
  input wire logic [2:0] ext,
  // Drive from the block.
  input wire logic [2:0] o,
  input wire logic [2:0] oe,
  // Wire levels fed back.
  output logic [2:0] pin
);
  // A driven pin shows the block's level, a free one the outside level.
  assign pin = (oe & o) | (~oe & ext);
endmodule

// file: testbench/pin_io_checker.sv
// Concurrent checks on the timer pin I/O ports.
`timescale 1ns/100ps
module pin_io_checker (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and strobes.
  input wire logic ch5_match_b,
  input wire logic ch5_pin_b_o,
  input wire logic ch5_pin_b_oe,
  input wire logic ch0_pin_a_oe,
  input wire logic ch0_pin_c_oe,
  input wire logic ch5_general_reg_b_capture,
  input wire logic ch0_general_reg_a_capture,
  input wire logic ch0_general_reg_c_capture
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken during response");
  property p_r_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken during response");
  property p_b_stand;
    $fell(s_axi_bvalid) |-> $past(s_axi_bready);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("bvalid dropped early");
  property p_r_stand;
    $fell(s_axi_rvalid) |-> $past(s_axi_rready);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("rvalid dropped early");
  property p_cap_b;
    ch5_general_reg_b_capture |-> !ch5_pin_b_oe;
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("b drives in capture");
  property p_cap_a;
    ch0_general_reg_a_capture |-> !ch0_pin_a_oe;
  endproperty
  a_cap_a: assert property (p_cap_a) else $error("a drives in capture");
  property p_cap_c;
    ch0_general_reg_c_capture |-> !ch0_pin_c_oe;
  endproperty
  a_cap_c: assert property (p_cap_c) else $error("c drives in capture");
  property p_pin_hold;
    ch5_pin_b_oe && $past(ch5_pin_b_oe) && !$past(ch5_match_b) && !s_axi_bvalid
      && !$past(s_axi_bvalid) |-> $stable(ch5_pin_b_o);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin moved without match");
endmodule
bind timer_pin_io_mode_control pin_io_checker chk (.*);

// file: testbench/tb_top.sv
// Self-checking bench for the timer pin I/O mode control.
`timescale 1ns/100ps
`define CHK(g, e) check(g, e)
module tb_top;
  logic aclk = 0, aresetn = 0;
  logic [3:0] s_axi_awaddr = '0, s_axi_wstrb = 4'h1, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_q;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ch5_match_b = 0, ch0_match_a = 0, ch0_match_c = 0, ch1_counter_tick = 0;
  logic [2:0] ext = '0;
  wire ch5_pin_b_i, ch0_pin_a_i, ch0_pin_c_i;
  logic ch5_pin_b_o, ch5_pin_b_oe, ch0_pin_a_o, ch0_pin_a_oe, ch0_pin_c_o, ch0_pin_c_oe;
  logic ch5_general_reg_b_capture, ch0_general_reg_a_capture, ch0_general_reg_c_capture;
  wire [2:0] oes = {ch0_pin_c_oe, ch0_pin_a_oe, ch5_pin_b_oe};
  wire [2:0] pos = {ch0_pin_c_o, ch0_pin_a_o, ch5_pin_b_o};
  int fail_count = 0, total_checks = 0, caps[3];
  always #12.5 aclk = ~aclk;
  timer_pin_io_mode_control dut (.*);
  pin_partner pins (.ext(ext), .o(pos), .oe(oes),
    .pin({ch0_pin_c_i, ch0_pin_a_i, ch5_pin_b_i}));
  always @(posedge aclk) begin
    caps[0] += ch5_general_reg_b_capture;
    caps[1] += ch0_general_reg_a_capture;
    caps[2] += ch0_general_reg_c_capture;
  end
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bound(input int i);
    if (i >= 50) begin
      fail_count++;
      tally_and_finish;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] r, output logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'h1; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    bound(i);
    d = s_axi_rdata;
    `CHK(s_axi_rresp, r);
    s_axi_rready <= 1'h0;
  endtask
  // One write with a chosen strobe; the response code is compared with the expected one.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'h1; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    bound(i);
    `CHK(s_axi_bresp, r);
    s_axi_bready <= 1'h0;
  endtask
  task automatic set(input logic [3:0] a, input logic [7:0] v);
    wr(a, {24'($urandom), v}, 4'h1, tpu_io_pkg::RESP_OKAY);
    rd(a, tpu_io_pkg::RESP_OKAY, rd_q);
    `CHK(rd_q, {24'h0, v});
  endtask
  // Holds reset for 16 cycles, then reads every register back at its reset value.
  task automatic reset_run;
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), tpu_io_pkg::RESP_OKAY, rd_q);
      `CHK(rd_q, i == 3 ? tpu_io_pkg::MODE_RESET : tpu_io_pkg::IO_RESET);
    end
    `CHK(oes, 3'h0);
  endtask
  function automatic int ecap(int m, bit ch0);
    if (m < 8) return 0;
    if (ch0 && m >= 12) return 1;
    return m % 4 >= 2 ? 2 : 1;
  endfunction
  // Sets one mode on all three registers, then drives matches, pin edges and a tick.
  task automatic mode_run(input int m, input bit bf);
    logic lvl;
    bit e;
    set(tpu_io_pkg::ADDR_IO_CH5, 8'(m << 4));
    set(tpu_io_pkg::ADDR_IO_HIGH_CH0, 8'(m));
    set(tpu_io_pkg::ADDR_IO_LOW_CH0, 8'(m));
    repeat (6) @(posedge aclk);
    e = m < 8 && m % 4 != 0;
    lvl = m[2];
    `CHK(oes, {!bf && e, e, e});
    for (int k = 0; k < 3; k++) begin
      if (e) `CHK(pos | {bf, 2'h0}, {bf | lvl, lvl, lvl});
      if (k < 2) begin
        @(posedge aclk) {ch0_match_c, ch0_match_a, ch5_match_b} <= 3'h7;
        @(posedge aclk) {ch0_match_c, ch0_match_a, ch5_match_b} <= 3'h0;
        lvl = m % 4 == 1 ? 1'h0 : m % 4 == 2 ? 1'h1 : !lvl;
        repeat (3) @(posedge aclk);
      end
    end
    #1 caps = '{0, 0, 0};
    @(posedge aclk) ext <= 3'h7;
    repeat (8 + $urandom % 8) @(posedge aclk);
    ext <= 3'h0;
    repeat (8 + $urandom % 8) @(posedge aclk);
    ch1_counter_tick <= 1'h1;
    @(posedge aclk) ch1_counter_tick <= 1'h0;
    repeat (6) @(posedge aclk);
    `CHK(caps[0], ecap(m, 0));
    `CHK(caps[1], ecap(m, 1));
    `CHK(caps[2], bf ? 0 : ecap(m, 1));
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h864dd62f));
    reset_run;
    // An unmapped address is refused, and a write without byte lane 0 changes nothing.
    wr(4'h2, 32'h0000_00ff, 4'h1, tpu_io_pkg::RESP_SLVERR);
    rd(4'h2, tpu_io_pkg::RESP_SLVERR, rd_q);
    `CHK(rd_q, 32'h0000_0000);
    wr(tpu_io_pkg::ADDR_IO_CH5, 32'h0000_00ff, 4'he, tpu_io_pkg::RESP_OKAY);
    rd(tpu_io_pkg::ADDR_IO_CH5, tpu_io_pkg::RESP_OKAY, rd_q);
    `CHK(rd_q, {24'h0, tpu_io_pkg::IO_RESET});
    for (int m = 0; m < 16; m++) mode_run(m, 1'h0);
    set(tpu_io_pkg::ADDR_MODE_CH0, 8'h10);
    mode_run(2, 1'h1);
    mode_run(9, 1'h1);
    mode_run(12, 1'h1);
    // A reset in mid-run clears the buffer enable, so register C works again.
    reset_run;
    mode_run(3, 1'h0);
    mode_run(10, 1'h0);
    tally_and_finish;
  end
endmodule
